// file: src/smb_pkg.sv
package smb_pkg;
  // ****************************************
  // master bit rates
  // ****************************************
  // half-period of master clock in CLK_SYS cycles, per rate select code
  // three at least: master-in passes a two-stage sync before capture
  localparam logic [4:0] DIV_HALF_0 = 5'h03;
  localparam logic [4:0] DIV_HALF_1 = 5'h04;
  localparam logic [4:0] DIV_HALF_2 = 5'h08;
  localparam logic [4:0] DIV_HALF_3 = 5'h10;
  // ****************************************
  // transfer framing
  // ****************************************
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] DIV_RESET = 5'h00;
  localparam logic [3:0] EDGE_RESET = 4'h0;
  localparam logic [2:0] BIT_RESET = 3'h0;
  localparam logic [1:0] RATE_RESET = 2'h0;

  typedef enum logic {ST_IDLE, ST_RUN} smb_state_e;
endpackage

// file: src/smb_engine.sv
// What this block does
// - full duplex, one byte out and one in together, MSB first
// - a transfer is exactly eight serial clock pulses
// - received byte replaces sent byte, one completion flag only
// - master offers four rates from two select bits, drives serial clock
// - master drives master-out line and samples master-in line
// - master role and enable stay set only while select input is high
// - master transfer starts on data write, byte loaded into shift register
// - completion flag set by hardware in master and slave mode
// - interrupt on completion or mode fault only if enabled, gated by cpu mask
// - received byte copied to buffer at completion, data reads return it
// - flag clears after status access while set, then data read
// - data writes ignored while flag set until status is read
// - slave uses external clock, ignores rate select bits
// - slave mode entered by clearing master role, setting enable
// - slave samples master-out line, drives master-in line
// - slave sends written byte on master-in line MSB first
// - slave transfer starts with external clock and MSB on master-out
// - unselected slave leaves its serial output undriven
// - master and slave share polarity and phase setting
// - polarity sets idle clock level; with phase picks capture edge
// - phase set captures on second edge, clear on first edge
// - data write during transfer discarded, sets collision flag
// - master seeing select low sets fault, clears enable and role
`timescale 1ns/1ps
module smb_engine (
  // system clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  // control word, taken on CTRL_WR
  input wire logic CTRL_WR,
  input wire logic CTRL_MASTER_ROLE,
  input wire logic CTRL_SERIAL_ENABLE,
  input wire logic CTRL_CLK_IDLE_LEVEL,
  input wire logic CTRL_CLK_CAPTURE_PHASE,
  input wire logic CTRL_RATE_SEL_HI,
  input wire logic CTRL_RATE_SEL_LO,
  input wire logic CTRL_XFER_IRQ_ENABLE,
  // data and status access
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WDATA,
  input wire logic DATA_RD,
  input wire logic STATUS_ACC,
  input wire logic CPU_IRQ_MASK,
  // status and data out
  output logic [7:0] RX_DATA,
  output logic XFER_DONE_FLAG,
  output logic WRITE_COLLISION_FLAG,
  output logic MODE_FAULT_FLAG,
  output logic MASTER_ROLE,
  output logic SERIAL_ENABLE,
  output logic BUSY,
  output logic IRQ,
  // serial pins
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic SS_N_I
);

  // ****************************************
  // system domain state
  // ****************************************
  typedef struct packed {
    smb_pkg::smb_state_e state;
    logic [4:0] div;
    logic [3:0] edge_cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sck;
    logic mosi;
    logic master_role;
    logic serial_enable;
    logic idle_level;
    logic phase;
    logic [1:0] rate;
    logic irq_en;
    logic done;
    logic done_armed;
    logic write_collision_flag;
    logic write_collision_flag_armed;
    logic mode_fault_flag;
    logic mode_fault_flag_armed;
    logic irq;
    logic sck_oe;
    logic mosi_oe;
    logic miso_oe;
    logic miso_s1;
    logic miso_s2;
    logic ss_s1;
    logic ss_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_seen;
    logic run;
  } smb_sys_s;

  smb_sys_s r;
  smb_sys_s next_r;

  // ****************************************
  // link domain state
  // ****************************************
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] rx;
  } smb_lnk_s;

  smb_lnk_s l;
  smb_lnk_s next_l;
  logic link_tgl;
  logic [7:0] link_hold;
  logic link_out;
  logic link_clk;
  logic link_clr;
  logic slave_on;

  function automatic logic [4:0] half_period(input logic [1:0] sel);
    if (sel == 2'h0) begin
      half_period = smb_pkg::DIV_HALF_0;
    end else if (sel == 2'h1) begin
      half_period = smb_pkg::DIV_HALF_1;
    end else if (sel == 2'h2) begin
      half_period = smb_pkg::DIV_HALF_2;
    end else begin
      half_period = smb_pkg::DIV_HALF_3;
    end
  endfunction

  // ****************************************
  // system domain next state
  // ****************************************
  logic busy;
  logic slave_done;
  logic master_done;
  logic cap_edge;
  logic wr_ok;

  always_comb begin
    next_r = r;
    busy = 1'b0;
    master_done = 1'b0;
    cap_edge = 1'b0;
    next_r.miso_s1 = MISO_I;
    next_r.miso_s2 = r.miso_s1;
    next_r.ss_s1 = SS_N_I;
    next_r.ss_s2 = r.ss_s1;
    next_r.tgl_s1 = link_tgl;
    next_r.tgl_s2 = r.tgl_s1;
    next_r.tgl_seen = r.tgl_s2;
    slave_done = (r.tgl_s2 != r.tgl_seen);

    // control word; role and enable locked while fault set and status not yet read
    if (CTRL_WR) begin
      next_r.idle_level = CTRL_CLK_IDLE_LEVEL;
      next_r.phase = CTRL_CLK_CAPTURE_PHASE;
      next_r.rate = {CTRL_RATE_SEL_HI, CTRL_RATE_SEL_LO};
      next_r.irq_en = CTRL_XFER_IRQ_ENABLE;
      if (!r.mode_fault_flag || r.mode_fault_flag_armed) begin
        next_r.master_role = CTRL_MASTER_ROLE;
        next_r.serial_enable = CTRL_SERIAL_ENABLE;
      end
      if (r.mode_fault_flag_armed) begin
        next_r.mode_fault_flag = 1'b0;
        next_r.mode_fault_flag_armed = 1'b0;
      end
    end

    // master state machine
    case (r.state)
      smb_pkg::ST_RUN: begin
        busy = 1'b1;
        if (r.div == 5'h01) begin
          next_r.div = half_period(r.rate);
          next_r.sck = !r.sck;
          next_r.edge_cnt = r.edge_cnt + 4'h1;
          cap_edge = (r.edge_cnt[0] == r.phase);
          if (cap_edge) begin
            next_r.sh = {r.sh[6:0], r.miso_s2};
          end else if (r.edge_cnt != smb_pkg::LAST_EDGE) begin
            next_r.mosi = r.sh[7];
          end
          if (r.edge_cnt == smb_pkg::LAST_EDGE) begin
            master_done = 1'b1;
            next_r.state = smb_pkg::ST_IDLE;
            next_r.rx = r.phase ? {r.sh[6:0], r.miso_s2} : r.sh;
          end
        end else begin
          next_r.div = r.div - 5'h01;
        end
      end
      default: begin
        next_r.state = smb_pkg::ST_IDLE;
      end
    endcase

    // slave counts as busy while selected
    if (!r.master_role && r.serial_enable && !r.ss_s2) begin
      busy = 1'b1;
    end

    wr_ok = !(r.done && !r.done_armed);
    if (DATA_WR && wr_ok && !busy) begin
      next_r.tx = DATA_WDATA;
      next_r.sh = DATA_WDATA;
      if (r.master_role && r.serial_enable) begin
        next_r.state = smb_pkg::ST_RUN;
        next_r.div = half_period(r.rate);
        next_r.edge_cnt = smb_pkg::EDGE_RESET;
        next_r.mosi = r.phase ? r.mosi : DATA_WDATA[7];
      end
    end

    // slave byte from link domain, rate bits unused
    if (slave_done) begin
      next_r.rx = link_hold;
    end

    if (STATUS_ACC && r.done) begin
      next_r.done_armed = 1'b1;
    end
    if (DATA_RD && r.done_armed) begin
      next_r.done = 1'b0;
      next_r.done_armed = 1'b0;
    end
    if (STATUS_ACC && r.write_collision_flag) begin
      next_r.write_collision_flag_armed = 1'b1;
    end
    if (DATA_RD && r.write_collision_flag_armed) begin
      next_r.write_collision_flag = 1'b0;
      next_r.write_collision_flag_armed = 1'b0;
    end
    // collision discards the write, set wins
    if (DATA_WR && wr_ok && busy) begin
      next_r.write_collision_flag = 1'b1;
    end
    if (STATUS_ACC && r.mode_fault_flag) begin
      next_r.mode_fault_flag_armed = 1'b1;
    end

    if (master_done || (slave_done && !r.master_role)) begin
      next_r.done = 1'b1;
      next_r.done_armed = 1'b0;
    end

    // select low on a master is a fault
    if (r.master_role && r.serial_enable && !r.ss_s2) begin
      next_r.mode_fault_flag = 1'b1;
      next_r.mode_fault_flag_armed = 1'b0;
      next_r.master_role = 1'b0;
      next_r.serial_enable = 1'b0;
      next_r.state = smb_pkg::ST_IDLE;
    end

    next_r.irq = (next_r.done || next_r.mode_fault_flag) && next_r.irq_en
      && !CPU_IRQ_MASK;
    if (next_r.state == smb_pkg::ST_IDLE) begin
      next_r.sck = next_r.idle_level;
    end
    next_r.sck_oe = next_r.master_role && next_r.serial_enable;
    next_r.mosi_oe = next_r.master_role && next_r.serial_enable;
    next_r.run = (next_r.state == smb_pkg::ST_RUN);
    next_r.miso_oe = !next_r.master_role && next_r.serial_enable && !r.ss_s2;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      r <= '0;
      r.ss_s1 <= 1'b1;
      r.ss_s2 <= 1'b1;
    end else if (CE) begin
      r <= next_r;
    end
  end

  // ****************************************
  // link domain (slave)
  // ****************************************
  // fold polarity and phase into one capture clock
  assign link_clk = SCK_I ^ (r.idle_level ^ r.phase);
  // slave mode from role and enable
  assign slave_on = r.serial_enable && !r.master_role;
  // frame counters restart whenever the select line goes high
  assign link_clr = SS_N_I || !slave_on;

  always_comb begin
    next_l.cnt = l.cnt + 3'h1;
    next_l.rx = {l.rx[5:0], MOSI_I};
  end

  always_ff @(posedge link_clk or posedge link_clr) begin
    if (link_clr) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // toggle and held byte survive frame clears for the crossing
  always_ff @(posedge link_clk or negedge RST_N) begin
    if (!RST_N) begin
      link_tgl <= 1'b0;
      link_hold <= smb_pkg::BYTE_RESET;
    end else if (!link_clr && l.cnt == smb_pkg::LAST_BIT) begin
      link_tgl <= !link_tgl;
      link_hold <= {l.rx, MOSI_I};
    end
  end

  // tx is frozen by the collision guard while selected
  always_ff @(negedge link_clk or posedge link_clr) begin
    if (link_clr) begin
      link_out <= 1'b0;
    end else begin
      link_out <= r.tx[3'h7 - l.cnt];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign RX_DATA = r.rx;
  assign XFER_DONE_FLAG = r.done;
  assign WRITE_COLLISION_FLAG = r.write_collision_flag;
  assign MODE_FAULT_FLAG = r.mode_fault_flag;
  assign MASTER_ROLE = r.master_role;
  assign SERIAL_ENABLE = r.serial_enable;
  assign BUSY = r.run;
  assign IRQ = r.irq;
  assign SCK_O = r.sck;
  assign SCK_OE = r.sck_oe;
  assign MOSI_O = r.mosi;
  assign MOSI_OE = r.mosi_oe;
  // phase clear needs the msb out before any clock edge arrives
  assign MISO_O = (!r.phase && l.cnt == smb_pkg::BIT_RESET) ? r.tx[7]
    : link_out;
  assign MISO_OE = r.miso_oe;

endmodule // smb_engine

// file: tb/smb_engine_monitor.sv
`timescale 1ns/1ps
module smb_engine_monitor (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // requests
  input wire logic CTRL_WR,
  input wire logic DATA_WR,
  input wire logic DATA_RD,
  input wire logic STATUS_ACC,
  input wire logic CPU_IRQ_MASK,
  input wire logic SS_N_I,
  // watched outputs
  input wire logic XFER_DONE_FLAG,
  input wire logic WRITE_COLLISION_FLAG,
  input wire logic MODE_FAULT_FLAG,
  input wire logic MASTER_ROLE,
  input wire logic SERIAL_ENABLE,
  input wire logic BUSY,
  input wire logic IRQ,
  input wire logic SCK_O,
  input wire logic SCK_OE,
  input wire logic MISO_OE
);
  // ****************************************
  // helpers
  // ****************************************
  logic sck_q, busy_q, seen;
  logic [4:0] edges;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // count runs one cycle past busy, in case the final edge lands late
  always_ff @(posedge CLK_SYS) begin
    sck_q <= SCK_O;
    busy_q <= BUSY;
    seen <= XFER_DONE_FLAG && (seen || STATUS_ACC);
    if (!RST_N || (!BUSY && !busy_q)) edges <= 5'h00;
    else if (SCK_O != sck_q) edges <= edges + 5'h01;
  end
  a_reset_quiet: assert property (
    $rose(RST_N) |-> !XFER_DONE_FLAG && !SCK_OE && !MISO_OE)
    else $error("outputs active after reset");
  a_miso_released: assert property (
    SS_N_I [*4] |-> !MISO_OE) else $error("unselected slave drives miso");
  a_idle_still: assert property (
    !BUSY && !$past(BUSY) && !$past(BUSY, 2) && SCK_OE && $past(SCK_OE)
    && !$past(CTRL_WR) |-> $stable(SCK_O)) else $error("idle clock moved");
  a_write_starts: assert property (
    DATA_WR && SCK_OE && !BUSY && !XFER_DONE_FLAG |=> BUSY)
    else $error("write did not start transfer");
  a_sixteen_edges: assert property (
    $fell(BUSY) |=> edges == 5'h10) else $error("edge count wrong");
  a_done_holds: assert property (
    XFER_DONE_FLAG && !DATA_RD |=> XFER_DONE_FLAG)
    else $error("done flag cleared early");
  a_write_ignored: assert property (
    XFER_DONE_FLAG && !seen && !STATUS_ACC && DATA_WR && !BUSY |=> !BUSY)
    else $error("write accepted while done set");
  a_collision_set: assert property (
    DATA_WR && BUSY && !XFER_DONE_FLAG |=> WRITE_COLLISION_FLAG)
    else $error("collision not flagged");
  a_irq_masked: assert property (
    CPU_IRQ_MASK && $past(CPU_IRQ_MASK) |-> !IRQ)
    else $error("irq while masked");
  a_fault_drop: assert property (
    SCK_OE && !SS_N_I ##1 !SS_N_I [*3] |-> ##[0:2]
    (MODE_FAULT_FLAG && !MASTER_ROLE && !SERIAL_ENABLE))
    else $error("mode fault not taken");
endmodule // smb_engine_monitor

// file: tb/smb_slave_model.sv
`timescale 1ns/1ps
module smb_slave_model (
  // wire side
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic idle_level,
  input wire logic phase,
  output logic miso,
  // byte side
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  // ****************************************
  // shift engine
  // ****************************************
  logic [7:0] sr;
  logic [3:0] cnt;
  wire logic lk = sck ^ (idle_level ^ phase);
  // released line shows an inverted level, never a held one
  assign miso = sel_n ? ~sr[7] : sr[7];
  always @(negedge sel_n) begin
    sr = tx;
    cnt = 4'h0;
  end
  // capture msb first on the chosen edge
  always @(posedge lk) if (!sel_n) begin
    rx = {rx[6:0], mosi};
    cnt = cnt + 4'h1;
  end
  // phase 1 shows the msb at the first edge, so no shift there
  always @(negedge lk) if (!sel_n && (!phase || cnt != 4'h0)) sr = sr << 1;
endmodule // smb_slave_model

// file: tb/smb_engine_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module smb_engine_tb_top;
  // ****************************************
  // wiring
  // ****************************************
  logic clk = 0, rst_n, ce = 1, ctrl_wr = 0, mask = 0, ss_n = 1, done_q = 0;
  logic tb_sck = 0, tb_mosi = 0, psel_n = 1;
  logic [6:0] cfg = 7'h00;
  logic [2:0] acc = 3'h0;
  logic [7:0] wdata = 8'h00, ptx = 8'h00, got, b, eb, cap;
  wire logic [7:0] rx, prx;
  wire logic done, write_collision_flag, fault, role, en, busy, irq, pmiso;
  wire logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  wire logic sck_w = sck_oe ? sck_o : tb_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire logic miso_w = miso_oe ? miso_o : pmiso;
  integer seed = 94, fails = 0, samples_checked = 0;
  logic [7:0] exp_q[$];
  smb_engine dut (.CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .CTRL_WR(ctrl_wr),
    .CTRL_MASTER_ROLE(cfg[6]), .CTRL_SERIAL_ENABLE(cfg[5]),
    .CTRL_CLK_IDLE_LEVEL(cfg[4]), .CTRL_CLK_CAPTURE_PHASE(cfg[3]),
    .CTRL_RATE_SEL_HI(cfg[2]), .CTRL_RATE_SEL_LO(cfg[1]),
    .CTRL_XFER_IRQ_ENABLE(cfg[0]), .DATA_WR(acc[0]), .DATA_WDATA(wdata),
    .DATA_RD(acc[1]), .STATUS_ACC(acc[2]), .CPU_IRQ_MASK(mask), .RX_DATA(rx),
    .XFER_DONE_FLAG(done), .WRITE_COLLISION_FLAG(write_collision_flag),
    .MODE_FAULT_FLAG(fault), .MASTER_ROLE(role), .SERIAL_ENABLE(en),
    .BUSY(busy), .IRQ(irq), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe),
    .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w),
    .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N_I(ss_n));
  smb_slave_model peer (.sck(sck_w), .mosi(mosi_w), .sel_n(psel_n),
    .idle_level(cfg[4]), .phase(cfg[3]), .miso(pmiso), .tx(ptx), .rx(prx));
  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ctl(input logic [6:0] c);
    @(posedge clk) begin cfg <= c; ctrl_wr <= 1'b1; end
    @(posedge clk) ctrl_wr <= 1'b0;
  endtask
  // acc bits: status access, data read, data write
  task automatic op(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) begin acc <= a; wdata <= d; end
    @(posedge clk) acc <= 3'h0;
    @(negedge clk);
  endtask
  task automatic wait_done;
    int k;
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk);
    if (done !== 1'b1) begin fails++; summarize(); end
    @(negedge clk);
  endtask
  always @(posedge clk) begin
    if (done === 1'b1 && done_q !== 1'b1 && exp_q.size() > 0) begin
      eb = exp_q.pop_front();
      `CHK("rx", eb, rx)
    end
    done_q <= done;
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    // x to low gives the link flops their reset edge
    rst_n <= 1'b0;
    tick(12);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("idle", 5'h00, {done, write_collision_flag, sck_oe, mosi_oe, miso_oe})
    // every rate and clock mode as master
    for (int i = 0; i < 4; i++) begin
      ctl({2'b11, i[1], i[0], i[1:0], 1'b1});
      b = 8'($random(seed));
      got = 8'($random(seed));
      @(posedge clk) begin ptx <= b; psel_n <= 1'b0; mask <= i[0] & i[1]; end
      exp_q.push_back(b);
      op(3'h1, got);
      tick(6);
      op(3'h1, ~got);
      wait_done();
      `CHK("write_collision_flag", 1'b1, write_collision_flag)
      `CHK("irq", (i != 3), irq)
      `CHK("prx", got, prx)
      op(3'h1, 8'h5a);
      `CHK("busy", 1'b0, busy)
      // flag cleared before the next byte
      op(3'h4, 8'h00);
      op(3'h2, 8'h00);
      `CHK("clr", 2'h0, {done, write_collision_flag})
      @(posedge clk) psel_n <= 1'b1;
    end
    ctl(7'h26);
    b = 8'($random(seed));
    op(3'h1, b);
    got = 8'($random(seed));
    exp_q.push_back(got);
    `CHK("miso_oe", 1'b0, miso_oe)
    @(posedge clk) ss_n <= 1'b0;
    tick(6);
    // 160 ns link, select low for the byte
    #7;
    for (int k = 7; k >= 0; k--) begin
      tb_mosi = got[k];
      #80 tb_sck = 1'b1;
      cap[k] = miso_w;
      #80 tb_sck = 1'b0;
    end
    wait_done();
    `CHK("miso", b, cap)
    @(posedge clk) ss_n <= 1'b1;
    op(3'h4, 8'h00);
    op(3'h2, 8'h00);
    // select pulled low on a master
    ctl(7'h60);
    @(posedge clk) ss_n <= 1'b0;
    tick(8);
    @(negedge clk);
    `CHK("fault", 3'h4, {fault, role, en})
    @(posedge clk) ss_n <= 1'b1;
    op(3'h4, 8'h00);
    ctl(7'h00);
    @(negedge clk);
    `CHK("fault_clr", 1'b0, fault)
    // frozen state ignores a control write
    @(posedge clk) ce <= 1'b0;
    ctl(7'h60);
    @(negedge clk);
    `CHK("ce", 2'h0, {role, en})
    @(posedge clk) ce <= 1'b1;
    summarize();
  end
endmodule // smb_engine_tb_top
bind smb_engine smb_engine_monitor mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .CTRL_WR(CTRL_WR), .DATA_WR(DATA_WR), .DATA_RD(DATA_RD),
  .STATUS_ACC(STATUS_ACC), .CPU_IRQ_MASK(CPU_IRQ_MASK), .SS_N_I(SS_N_I),
  .XFER_DONE_FLAG(XFER_DONE_FLAG),
  .WRITE_COLLISION_FLAG(WRITE_COLLISION_FLAG),
  .MODE_FAULT_FLAG(MODE_FAULT_FLAG), .MASTER_ROLE(MASTER_ROLE),
  .SERIAL_ENABLE(SERIAL_ENABLE), .BUSY(BUSY), .IRQ(IRQ), .SCK_O(SCK_O),
  .SCK_OE(SCK_OE), .MISO_OE(MISO_OE));
